// [logic/seq_defs.vh]
// Constants shared by the parameter set sequencer files.
`ifndef SEQ_DEFS_VH
`define SEQ_DEFS_VH

`define SEQ_IDX_W        6
`define SEQ_SETS         64
`define SEQ_PARAM_W      32
`define SEQ_DEF_PARAM    32'h0000_0000
`define SEQ_LIMIT_RST    7'h02
`define SEQ_LIMIT_MAX    7'h40
`define SEQ_COPY_CYC     4'h4

`define ADDR_CTRL        4'h0
`define ADDR_LIMIT       4'h1
`define ADDR_ADV_SRC     4'h2
`define ADDR_RST_SRC     4'h3
`define ADDR_SLOT        4'h4
`define ADDR_CMD         4'h5
`define ADDR_ACTIVE      4'h6
`define ADDR_STATUS      4'h7

`define CTRL_ON_BIT      0
`define CTRL_POLICY_BIT  1
`define CMD_ADV_BIT      0
`define CMD_RST_BIT      1
`define CMD_SAVE_BIT     2
`define CMD_FETCH_BIT    3

`define ORG_ALWAYS       2'h0
`define ORG_LINE1        2'h1
`define ORG_LINE2        2'h2
`define ORG_DISABLED     2'h3

`endif

// [logic/set_store.v]
// Storage for the 64 stored parameter sets with per-slot written flags.
`timescale 1ns/10ps
module set_store (
	input  wire        clk,    // System clock.
	input  wire        resetn, // Synchronous reset, active low.
	input  wire        we,     // Write strobe.
	input  wire [5:0]  waddr,  // Write slot.
	input  wire [31:0] wdata,  // Write data.
	input  wire [5:0]  raddr,  // Read slot.
	output reg  [31:0] rdata   // Read data, one cycle later.
);
`include "seq_defs.vh"

	reg [31:0] mem [0:63];
	reg [63:0] written_reg;

	// ======================================================
	// Storage
	// Never-stored slots read default values.
	always @(posedge clk) begin
		if (we)
			mem[waddr] <= wdata;
		if (!resetn) begin
			written_reg <= 64'h0;
			rdata       <= `SEQ_DEF_PARAM;
		end else begin
			if (we)
				written_reg[waddr] <= 1'b1;
			if (written_reg[raddr] && !(we && waddr == raddr))
				rdata <= mem[raddr];
			else if (we && waddr == raddr)
				rdata <= wdata;
			else
				rdata <= `SEQ_DEF_PARAM;
		end
	end
endmodule

// [logic/param_sequencer.v]
// Parameter set sequencer: stepping of stored sets into the active set.
`timescale 1ns/10ps
module param_sequencer (
	input  wire        clk,          // System clock, 100 MHz.
	input  wire        resetn,       // Synchronous reset, active low.
	input  wire [3:0]  addr,         // Register address.
	input  wire [31:0] wdata,        // Register write data.
	input  wire        wr,           // Write strobe.
	input  wire        rd,           // Read strobe.
	output reg  [31:0] rdata,        // Read data, cycle after rd.
	input  wire        frame_trig,   // Frame start trigger pin.
	input  wire        line1,        // Input line 1 pin.
	input  wire        line2,        // Input line 2 pin.
	input  wire        frame_done,   // Frame transmitted, one pulse.
	output reg         waiting,      // Waiting for frame start trigger.
	output reg         acq_start,    // Accepted trigger pulse.
	output reg  [31:0] acq_params,   // Parameters used by acquisition.
	output reg  [5:0]  cur_index     // Current set index.
);
`include "seq_defs.vh"

	localparam ST_IDLE = 3'h0;
	localparam ST_COPY = 3'h1;
	localparam ST_WAIT = 3'h2;
	localparam ST_ACQ  = 3'h3;
	localparam ST_SAVE = 3'h4;

	// ======================================================
	// Input synchronisers
	// Lines and trigger are asynchronous pins; two stages guard metastability.
	reg [2:0] pin_s1_reg;
	reg [2:0] pin_s2_reg;
	reg       trig_d_reg;
	always @(posedge clk) begin
		if (!resetn) begin
			pin_s1_reg <= 3'h0;
			pin_s2_reg <= 3'h0;
			trig_d_reg <= 1'b0;
		end else begin
			pin_s1_reg <= {line2, line1, frame_trig};
			pin_s2_reg <= pin_s1_reg;
			trig_d_reg <= pin_s2_reg[0];
		end
	end
	wire trig_rise = pin_s2_reg[0] & ~trig_d_reg;
	wire l1 = pin_s2_reg[1];
	wire l2 = pin_s2_reg[2];

	// ======================================================
	// Configuration registers
	reg        on_reg;
	reg        policy_reg;
	reg [6:0]  limit_reg;
	reg [1:0]  adv_src_reg;
	reg [1:0]  rst_src_reg;
	reg [5:0]  slot_reg;
	reg [31:0] active_reg;
	reg [31:0] saved_reg;
	reg        adv_pend_reg;
	reg        rst_pend_reg;
	reg        save_pend_reg;
	reg        fetch_pend_reg;
	reg [2:0]  state_reg;
	reg [5:0]  idx_reg;
	reg [5:0]  load_idx_reg;
	reg [3:0]  cnt_reg;
	reg        off_pend_reg;
	wire [31:0] store_q;

	wire wr_cmd = wr && addr == `ADDR_CMD;
	wire wr_on  = wr && addr == `ADDR_CTRL;

	// Origin test shared by advance and restart.
	function origin_hit;
		input [1:0] org;
		input       a;
		input       b;
		begin
			case (org)
			`ORG_ALWAYS: origin_hit = 1'b1;
			`ORG_LINE1:  origin_hit = a;
			`ORG_LINE2:  origin_hit = b;
			default:     origin_hit = 1'b0;
			endcase
		end
	endfunction

	// wrap to zero at the limit
	// A limit of one keeps the index at zero.
	function [5:0] next_idx;
		input [5:0] i;
		input [6:0] lim;
		begin
			if ({1'b0, i} >= lim - 7'h01)
				next_idx = 6'h00;
			else
				next_idx = i + 6'h01;
		end
	endfunction

	wire adv_sync = origin_hit(adv_src_reg, l1, l2);
	wire rst_sync = (rst_src_reg != `ORG_ALWAYS) &&
		origin_hit(rst_src_reg, l1, l2);

	always @(posedge clk) begin
		if (!resetn) begin
			on_reg      <= 1'b0;
			policy_reg  <= 1'b0;
			limit_reg   <= `SEQ_LIMIT_RST;
			adv_src_reg <= `ORG_DISABLED;
			rst_src_reg <= `ORG_DISABLED;
			slot_reg    <= 6'h00;
		end else if (wr) begin
			case (addr)
			`ADDR_CTRL: begin
				on_reg     <= wdata[`CTRL_ON_BIT];
				policy_reg <= wdata[`CTRL_POLICY_BIT];
			end
			`ADDR_LIMIT:
				if (wdata[6:0] != 7'h00 && wdata[6:0] <= `SEQ_LIMIT_MAX)
					limit_reg <= wdata[6:0];
			`ADDR_ADV_SRC: adv_src_reg <= wdata[1:0];
			`ADDR_RST_SRC:
				if (wdata[1:0] != `ORG_ALWAYS)
					rst_src_reg <= wdata[1:0];
			`ADDR_SLOT: slot_reg <= wdata[5:0];
			default: ;
			endcase
		end
	end

	// ======================================================
	// Sequencer
	// The store answers one cycle after its address, so a copy lasts
	// several cycles; RAM timing is the price for a compact array.
	wire copy_done = cnt_reg == `SEQ_COPY_CYC;
	// A trigger counts only once waiting has been shown for a cycle, so
	// the source never sees a trigger taken while the flag was low.
	// discard unless waiting
	wire trig_take = trig_rise && waiting;
	always @(posedge clk) begin
		if (!resetn) begin
			state_reg      <= ST_IDLE;
			idx_reg        <= 6'h00;
			load_idx_reg   <= 6'h00;
			cnt_reg        <= 4'h0;
			active_reg     <= `SEQ_DEF_PARAM;
			saved_reg      <= `SEQ_DEF_PARAM;
			adv_pend_reg   <= 1'b0;
			rst_pend_reg   <= 1'b0;
			save_pend_reg  <= 1'b0;
			fetch_pend_reg <= 1'b0;
			off_pend_reg   <= 1'b0;
			acq_start      <= 1'b0;
			acq_params     <= `SEQ_DEF_PARAM;
		end else begin
			acq_start <= 1'b0;
			if (wr && addr == `ADDR_ACTIVE && state_reg == ST_IDLE)
				active_reg <= wdata;
			case (state_reg)
			ST_IDLE: begin
				cnt_reg <= 4'h0;
				if (wr_on && wdata[`CTRL_ON_BIT] && !on_reg) begin
					saved_reg    <= active_reg;
					idx_reg      <= 6'h00;
					load_idx_reg <= 6'h00;
					state_reg    <= ST_COPY;
				end else if (save_pend_reg) begin
					// Save and fetch wait for the idle state; a copy in
					// flight would otherwise race the store port.
					save_pend_reg <= 1'b0;
					state_reg     <= ST_SAVE;
				end else if (fetch_pend_reg) begin
					fetch_pend_reg <= 1'b0;
					load_idx_reg   <= slot_reg;
					state_reg      <= ST_COPY;
				end
			end
			ST_SAVE:
				state_reg <= ST_IDLE;
			ST_COPY: begin
				// The count spans the store latency with margin; the
				// active set changes only at its end.
				cnt_reg <= cnt_reg + 4'h1;
				if (copy_done) begin
					active_reg <= store_q;
					state_reg  <= on_reg ? ST_WAIT : ST_IDLE;
				end
			end
			ST_WAIT: begin
				cnt_reg <= 4'h0;
				if (!on_reg) begin
					active_reg <= saved_reg;
					state_reg  <= ST_IDLE;
				end else if (rst_pend_reg) begin
					rst_pend_reg <= 1'b0;
					adv_pend_reg <= 1'b0;
					idx_reg      <= 6'h00;
					load_idx_reg <= 6'h00;
					state_reg    <= ST_COPY;
				end else if (adv_pend_reg) begin
					adv_pend_reg <= 1'b0;
					idx_reg      <= next_idx(idx_reg, limit_reg);
					load_idx_reg <= next_idx(idx_reg, limit_reg);
					state_reg    <= ST_COPY;
				end else if (trig_take) begin
					acq_start <= 1'b1;
					off_pend_reg <= 1'b0;
					state_reg <= ST_ACQ;
					if (rst_sync) begin
						idx_reg      <= 6'h00;
						load_idx_reg <= 6'h00;
						acq_params   <= store_q;
						active_reg   <= store_q;
					end else if (adv_sync) begin
						idx_reg      <= next_idx(idx_reg, limit_reg);
						load_idx_reg <= next_idx(idx_reg, limit_reg);
						acq_params   <= active_reg;
					end else
						acq_params <= active_reg;
				end
			end
			ST_ACQ: begin
				if (!on_reg)
					off_pend_reg <= 1'b1;
				if (frame_done) begin
					if (!on_reg || off_pend_reg) begin
						active_reg <= saved_reg;
						state_reg  <= ST_IDLE;
					end else if (load_idx_reg != idx_reg ||
						adv_sync)
						state_reg <= ST_COPY;
					else
						state_reg <= ST_WAIT;
				end
			end
			default:
				state_reg <= ST_IDLE;
			endcase
			// Commands are captured after the state case so that one
			// arriving as its flag is consumed is kept, not lost.
			if (wr_cmd && wdata[`CMD_ADV_BIT])
				adv_pend_reg <= 1'b1;
			if (wr_cmd && wdata[`CMD_RST_BIT])
				rst_pend_reg <= 1'b1;
			if (wr_cmd && wdata[`CMD_SAVE_BIT])
				save_pend_reg <= 1'b1;
			if (wr_cmd && wdata[`CMD_FETCH_BIT])
				fetch_pend_reg <= 1'b1;
		end
	end

	// ======================================================
	// Status outputs
	always @(posedge clk) begin
		if (!resetn) begin
			waiting   <= 1'b0;
			cur_index <= 6'h00;
			rdata     <= 32'h0000_0000;
		end else begin
			// leave waiting during copy
			// Waiting falls in the cycle a trigger is taken.
			waiting   <= state_reg == ST_WAIT && !adv_pend_reg &&
				!rst_pend_reg &&
				!trig_take;
			cur_index <= idx_reg;
			rdata     <= 32'h0000_0000;
			if (rd) begin
				case (addr)
				`ADDR_CTRL:    rdata <= {30'h0, policy_reg, on_reg};
				`ADDR_LIMIT:   rdata <= {25'h0, limit_reg};
				`ADDR_ADV_SRC: rdata <= {30'h0, adv_src_reg};
				`ADDR_RST_SRC: rdata <= {30'h0, rst_src_reg};
				`ADDR_SLOT:    rdata <= {26'h0, slot_reg};
				`ADDR_ACTIVE:  rdata <= active_reg;
				`ADDR_STATUS:  rdata <= {23'h0, idx_reg, state_reg};
				default:       rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ======================================================
	// Store read address
	// While restart may come from a line, the wait state keeps set zero
	// on the read port, so a restart trigger finds it already read.
	// set zero ready
	wire [5:0] store_raddr = (state_reg == ST_WAIT &&
		rst_src_reg != `ORG_DISABLED) ? 6'h00 : load_idx_reg;

	// ======================================================
	// Stored sets
	// defaults for unstored
	set_store u_store (
		.clk    (clk),
		.resetn (resetn),
		.we     (state_reg == ST_SAVE),
		.waddr  (slot_reg),
		.wdata  (active_reg),
		.raddr  (store_raddr),
		.rdata  (store_q)
	);
endmodule

// [verif/param_sequencer_sva.sv]
// Assertion checker for the parameter set sequencer ports.
`timescale 1ns/10ps
module param_sequencer_sva (
	input wire        clk,        // System clock.
	input wire        resetn,     // Reset, active low.
	input wire        rd,         // Read strobe.
	input wire [31:0] rdata,      // Read data.
	input wire        waiting,    // Waiting for trigger.
	input wire        acq_start,  // Accepted trigger pulse.
	input wire [31:0] acq_params, // Parameters in use.
	input wire [5:0]  cur_index   // Current set index.
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// ========================================
	// Trigger acceptance
	// accept only waiting.
	trig_needs_wait_a: assert property (acq_start |-> $past(waiting))
		else $error("trigger accepted while not waiting");
	start_pulse_a: assert property (acq_start |=> !acq_start)
		else $error("start pulse longer than one cycle");
	start_drops_a: assert property (acq_start |-> !waiting)
		else $error("still waiting at start");
	busy_after_a: assert property (acq_start |=> !waiting [*2])
		else $error("waiting during acquisition");
	params_hold_a: assert property (acq_start |=> ##1 $stable(acq_params) [*3])
		else $error("parameters changed during frame");
	// ========================================
	// Set index
	// step or wrap.
	index_step_a: assert property ($changed(cur_index) |->
		cur_index == $past(cur_index) + 6'h1 || cur_index == 6'h0)
		else $error("index moved by other than one");
	index_copy_a: assert property ($changed(cur_index) |-> !waiting)
		else $error("index changed while waiting");
	// Read data stand only after a read.
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside read cycle");
	start_c: cover property (acq_start);
	wrap_c: cover property ($changed(cur_index) && cur_index == 6'h0);
	copy_c: cover property ($fell(waiting) && !acq_start);
endmodule
bind param_sequencer param_sequencer_sva param_sequencer_sva_i (
	.clk(clk), .resetn(resetn), .rd(rd), .rdata(rdata),
	.waiting(waiting), .acq_start(acq_start),
	.acq_params(acq_params), .cur_index(cur_index));

// [verif/trig_source.sv]
// Frame trigger source and frame timing model.
`timescale 1ns/10ps
module trig_source (
	input  wire       clk,        // System clock.
	input  wire       waiting,    // Device waiting flag.
	input  wire       acq_start,  // Device start pulse.
	input  wire       go,         // Request one frame.
	input  wire [3:0] dly,        // Frame length in cycles.
	output reg        frame_trig, // Trigger pin.
	output reg        frame_done, // Frame sent pulse.
	output reg        busy        // Frame in flight.
);
	integer n;
	initial begin
		frame_trig = 1'b0;
		frame_done = 1'b0;
		busy = 1'b0;
		forever begin
			@(posedge clk);
			if (go) begin
				busy <= 1'b1;
				n = 0;
				while (!waiting && n < 300) begin
					@(posedge clk);
					n = n + 1;
				end
				frame_trig <= 1'b1;
				n = 0;
				while (!acq_start && n < 20) begin
					@(posedge clk);
					n = n + 1;
				end
				frame_trig <= 1'b0;
				repeat (dly) @(posedge clk);
				frame_done <= 1'b1;
				@(posedge clk);
				frame_done <= 1'b0;
				busy <= 1'b0;
			end
		end
	end
endmodule

// [verif/param_sequencer_tb.sv]
// Self-checking bench for the parameter set sequencer.
`timescale 1ns/10ps
`include "seq_defs.vh"
module param_sequencer_tb;
	reg         clk = 1'b0;
	reg         resetn = 1'b0;
	reg  [3:0]  addr = 4'h0;
	reg  [31:0] wdata = 32'h0;
	reg         wr = 1'b0;
	reg         rd = 1'b0;
	reg         line1 = 1'b0;
	reg         line2 = 1'b0;
	reg         go = 1'b0;
	reg  [3:0]  dly = 4'h4;
	wire [31:0] rdata;
	wire [31:0] acq_params;
	wire [5:0]  cur_index;
	wire        frame_trig, frame_done, waiting, acq_start, busy;
	integer     num_errors = 0;
	integer     cmp_count = 0;
	integer     k;
	always #5 clk = ~clk;
	param_sequencer param_sequencer_i (.clk(clk), .resetn(resetn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.frame_trig(frame_trig), .line1(line1), .line2(line2),
		.frame_done(frame_done), .waiting(waiting),
		.acq_start(acq_start), .acq_params(acq_params),
		.cur_index(cur_index));
	trig_source trig_source_i (.clk(clk), .waiting(waiting),
		.acq_start(acq_start), .go(go), .dly(dly),
		.frame_trig(frame_trig), .frame_done(frame_done), .busy(busy));
	// ========================================
	// Access tasks
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		begin
			cmp_count = cmp_count + 1;
			if (got !== exp) begin
				$display("ERROR %s exp %h got %h", nm, exp, got);
				num_errors = num_errors + 1;
			end
		end
	endtask
	task wr_reg(input [3:0] a, input [31:0] d);
		begin
			addr <= a;
			wdata <= d;
			wr <= 1'b1;
			@(posedge clk);
			wr <= 1'b0;
			@(posedge clk);
		end
	endtask
	task rd_chk(input [3:0] a, input [31:0] exp, input string nm);
		begin
			addr <= a;
			rd <= 1'b1;
			@(posedge clk);
			rd <= 1'b0;
			#1 chk(nm, exp, rdata);
			@(posedge clk);
		end
	endtask
	// Lets a pending command take effect, then waits for the trigger wait.
	task settle;
		integer n;
		begin
			n = 0;
			repeat (12) @(posedge clk);
			while (!waiting && n < 200) begin
				@(posedge clk);
				n = n + 1;
			end
		end
	endtask
	task frame(input [31:0] exp, input string nm, input dis);
		integer n;
		begin
			n = 0;
			go <= 1'b1;
			@(posedge clk);
			go <= 1'b0;
			#1;
			while (acq_start !== 1'b1 && n < 300) begin
				@(posedge clk);
				#1 n = n + 1;
			end
			chk(nm, exp, acq_params);
			@(posedge clk);
			if (dis)
				wr_reg(`ADDR_CTRL, 32'h0);
			n = 0;
			while (busy && n < 300) begin
				@(posedge clk);
				n = n + 1;
			end
			settle;
		end
	endtask
	task finish_test;
		begin
			$display("compares %0d errors %0d", cmp_count, num_errors);
			if (num_errors == 0 && cmp_count > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	// ========================================
	// Tests
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		rd_chk(`ADDR_LIMIT, `SEQ_LIMIT_RST, "limit");
		for (k = 0; k < 3; k = k + 1) begin
			wr_reg(`ADDR_ACTIVE, 32'ha0 + k);
			wr_reg(`ADDR_SLOT, k);
			wr_reg(`ADDR_CMD, 32'h4);
			@(posedge clk);
		end
		wr_reg(`ADDR_SLOT, 32'h3f);
		wr_reg(`ADDR_CMD, 32'h8);
		repeat (8) @(posedge clk);
		rd_chk(`ADDR_ACTIVE, `SEQ_DEF_PARAM, "unstored");
		wr_reg(`ADDR_SLOT, 32'h1);
		wr_reg(`ADDR_CMD, 32'h8);
		repeat (8) @(posedge clk);
		rd_chk(`ADDR_ACTIVE, 32'ha1, "fetched");
		wr_reg(`ADDR_ACTIVE, 32'h55);
		wr_reg(`ADDR_LIMIT, 32'h3);
		wr_reg(`ADDR_ADV_SRC, {30'h0, `ORG_DISABLED});
		wr_reg(`ADDR_RST_SRC, {30'h0, `ORG_ALWAYS});
		rd_chk(`ADDR_RST_SRC, {30'h0, `ORG_DISABLED}, "rst_src");
		wr_reg(`ADDR_CTRL, 32'h1);
		settle;
		frame(32'ha0, "enable_set", 1'b0);
		frame(32'ha0, "no_step", 1'b0);
		for (k = 1; k < 4; k = k + 1) begin
			wr_reg(`ADDR_CMD, 32'h1);
			settle;
			frame(32'ha0 + k % 3, "advance", 1'b0);
			chk("index", k % 3, cur_index);
		end
		wr_reg(`ADDR_CMD, 32'h1);
		settle;
		wr_reg(`ADDR_CMD, 32'h2);
		settle;
		frame(32'ha0, "restart", 1'b0);
		dly <= 4'hc;
		frame(32'ha0, "disable", 1'b1);
		rd_chk(`ADDR_ACTIVE, 32'h55, "restored");
		dly <= 4'h4;
		wr_reg(`ADDR_ADV_SRC, {30'h0, `ORG_LINE1});
		wr_reg(`ADDR_RST_SRC, {30'h0, `ORG_LINE2});
		line1 <= 1'b1;
		wr_reg(`ADDR_CTRL, 32'h1);
		settle;
		frame(32'ha0, "line_set0", 1'b0);
		frame(32'ha1, "line_set1", 1'b0);
		line2 <= 1'b1;
		settle;
		frame(32'ha0, "line_restart", 1'b0);
		line1 <= 1'b0;
		line2 <= 1'b0;
		settle;
		frame(32'ha0, "line_low", 1'b0);
		finish_test;
	end
	initial begin
		#200000;
		num_errors = num_errors + 1;
		finish_test;
	end
endmodule
